// ### inc/ecp_port_map.svh
// Offsets, field positions and reset values of the extended parallel port.
// Assumes offsets are relative to the port base, extended block at +0x400.
`ifndef ECP_PORT_MAP_SVH
`define ECP_PORT_MAP_SVH
`define ECP_OFF_DATA     11'h000
`define ECP_OFF_DSR      11'h001
`define ECP_OFF_DCR      11'h002
`define ECP_OFF_FIFO     11'h400
`define ECP_OFF_CFGB     11'h401
`define ECP_OFF_ECR      11'h402
`define ECP_CFGA_VAL     8'h10
`define ECP_CFGB_LOW_RST 3'h7
`define ECP_DCR_RST      6'h04
`define ECP_FIFO_DEPTH   5'h10
`define ECP_ECR_MASK     4
`define ECP_ECR_DMA_ENABLE_BIT    3
`define ECP_ECR_SVC      2
`define ECP_DCR_DIR      5
`define ECP_DCR_SELIN    3
`define ECP_DCR_NINIT    2
`define ECP_DCR_AFD      1
`define ECP_DCR_STB      0
`endif

// ### inc/ecp_pkg.sv
// Types shared by the extended parallel port and its FIFO.
// Assumes ecp_port_map.svh supplies the numeric constants.
package ecp_pkg;
  typedef enum logic [2:0] {
    ECP_M_STD   = 3'h0,
    ECP_M_BIDIR = 3'h1,
    ECP_M_COMPAT_FIFO_PORT = 3'h2,
    ECP_M_ECP   = 3'h3,
    ECP_M_EPP   = 3'h4,
    ECP_M_RSVD  = 3'h5,
    ECP_M_TEST  = 3'h6,
    ECP_M_CFG   = 3'h7
  } ecp_mode_t;
  typedef enum logic [1:0] {
    ECP_LK_IDLE = 2'h0,
    ECP_LK_ACT  = 2'h1,
    ECP_LK_WAIT = 2'h3,
    ECP_LK_DONE = 2'h2
  } ecp_lnk_t;
  typedef struct packed {
    logic [10:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } ecp_req_t;
  typedef struct packed {
    logic [7:0] pd;
    logic       nAck;
    logic       busy;
    logic       pError;
    logic       select;
    logic       nFault;
  } ecp_line_t;
endpackage : ecp_pkg

// ### rtl/ecp_byte_fifo.sv
// Shared 16-entry FIFO of tagged bytes (bit 8 = data/command tag).
// A push when full and a pop when empty are ignored.
`timescale 1ns/1ps
`include "ecp_port_map.svh"
module ecp_byte_fifo
  import ecp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       clear,
  input  wire logic       push,
  input  wire logic [8:0] pushData,
  input  wire logic       pop,
  output logic      [8:0] head,
  output logic      [4:0] count,
  output logic            full,
  output logic            empty
);
  logic [8:0] mem [16];
  logic [3:0] wrPtr_reg;
  logic [3:0] rdPtr_reg;
  logic [4:0] count_reg;
  logic       doPush;
  logic       doPop;

  assign full   = (count_reg == `ECP_FIFO_DEPTH);
  assign empty  = (count_reg == 5'h00);
  assign doPush = push && !full;
  assign doPop  = pop && !empty;
  assign head   = mem[rdPtr_reg];
  assign count  = count_reg;

  for (genvar i = 0; i < 16; i++) begin : g_ent
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        mem[i] <= 9'h000;
      end else if (doPush && wrPtr_reg == 4'(i)) begin
        mem[i] <= pushData;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_reg <= 4'h0;
      rdPtr_reg <= 4'h0;
      count_reg <= 5'h00;
    end else if (clear) begin
      wrPtr_reg <= 4'h0;
      rdPtr_reg <= 4'h0;
      count_reg <= 5'h00;
    end else begin
      if (doPush) wrPtr_reg <= wrPtr_reg + 4'h1;
      if (doPop) rdPtr_reg <= rdPtr_reg + 4'h1;
      if (doPush && !doPop) count_reg <= count_reg + 5'h01;
      else if (doPop && !doPush) count_reg <= count_reg - 5'h01;
    end
  end
endmodule : ecp_byte_fifo

// ### rtl/ecp_port_extended_control.sv
// Extended control of a host parallel port: modes, shared FIFO, DMA and
// service events, capability registers and the cable handshake.
// Assumes a synchronous register strobe port and DMA acknowledge/TC pins.
// What this block does
// (RULE1) Test mode moves FIFO bytes, never strobes cable
// (RULE2) First capability register always reads 10H
// (RULE3) Second capability bit 7 reads zero
// (RULE4) Second capability bit 6 shows IRQ level
// (RULE5) Bits 5-3 report the assigned interrupt
// (RULE6) Mode field read/write; standard mode clears FIFO
// (RULE7) Mode 001: direction tri-states, data reads lines
// (RULE8) Mode 010 sends FIFO with compatible handshake
// (RULE9) Mode 011 sends tagged queue, packs reverse bytes
// (RULE10) Mode 100 EPP only when option present
// (RULE11) Capability registers visible only in mode 111
// (RULE12) Fault edge interrupts unless masked; unmask re-fires
// (RULE13) DMA enable clear means no DMA request
// (RULE14) Service bit masks DMA; software clears it
// (RULE15) Terminal count sets service bit under DMA
// (RULE16) Forward: free space at or over threshold sets service
// (RULE17) Reverse: fill at or over threshold sets service
// (RULE18) Full and empty flags read back live
// (RULE19) All FIFO ports share one queue
// (RULE20) Ack line tags data high, command low
// (RULE21) Reverse needs request and peripheral acknowledge
// (RULE22) Select-in output stays high in ECP mode
// (RULE23) Software can write any mode directly from any other mode
// (RULE24) FIFO held disabled after reset
// (RULE25) DMA request fills or drains the FIFO
// (RULE26) Reset gives standard mode, DMA disabled
`timescale 1ns/1ps
`include "ecp_port_map.svh"
module ecp_port_extended_control
  import ecp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire ecp_req_t   busReq,
  input  wire logic       dmaAck,
  input  wire logic       dmaTc,
  input  wire ecp_line_t  lineIn,
  input  wire logic       irqLevel,
  input  wire logic [2:0] irqSelect,
  input  wire logic       eppOption,
  input  wire logic [4:0] writeThreshold,
  input  wire logic [4:0] readThreshold,
  output logic      [7:0] regRdata,
  output logic      [7:0] pdOut,
  output logic            pdOe,
  output logic            nStrobe,
  output logic            nAutoFd,
  output logic            nInit,
  output logic            nSelectIn,
  output logic            portDmaReq,
  output logic            faultIrq,
  output logic            serviceIrq,
  output logic            eppActive
);
  ecp_mode_t  mode_reg;
  ecp_lnk_t   lnk_reg;
  ecp_lnk_t   lnk_next;
  logic       faultMask_reg;
  logic       dma_enable_bit_reg;
  logic       svc_reg;
  logic       svc_next;
  logic [5:0] dcr_reg;
  logic [7:0] dataLatch_reg;
  logic [2:0] cfgbLow_reg;
  logic       nFaultPrev_reg;
  logic       lnkRev_reg;
  logic [8:0] lnkByte_reg;
  logic [7:0] regRdata_reg;
  logic [7:0] pdOut_reg;
  logic       pdOe_reg;
  logic       nStrobe_reg;
  logic       nAutoFd_reg;
  logic       nInit_reg;
  logic       nSelectIn_reg;
  logic       portDmaReq_reg;
  logic       faultIrq_reg;
  logic       serviceIrq_reg;
  logic       eppActive_reg;
  logic       wrData;
  logic       wrFifo;
  logic       wrCfgb;
  logic       wrEcr;
  logic       wrDcr;
  logic       rdFifo;
  logic       fifoMode;
  logic       dirRev;
  logic       hostPush;
  logic       hostPop;
  logic       dmaPush;
  logic       dmaPop;
  logic       lnkPush;
  logic       lnkPop;
  logic       lnkStart;
  logic       fwdGo;
  logic       revGo;
  logic       svcSet;
  logic       fifoClear;
  logic       fifoFull;
  logic       fifoEmpty;
  logic [8:0] fifoHead;
  logic [4:0] fifoCount;
  logic [4:0] fifoFree;
  logic [7:0] rdNext;

  assign regRdata   = regRdata_reg;
  assign pdOut      = pdOut_reg;
  assign pdOe       = pdOe_reg;
  assign nStrobe    = nStrobe_reg;
  assign nAutoFd    = nAutoFd_reg;
  assign nInit      = nInit_reg;
  assign nSelectIn  = nSelectIn_reg;
  assign portDmaReq = portDmaReq_reg;
  assign faultIrq   = faultIrq_reg;
  assign serviceIrq = serviceIrq_reg;
  assign eppActive  = eppActive_reg;

  assign wrData = busReq.wr && busReq.addr == `ECP_OFF_DATA;
  assign wrDcr  = busReq.wr && busReq.addr == `ECP_OFF_DCR;
  assign wrFifo = busReq.wr && busReq.addr == `ECP_OFF_FIFO;
  assign wrCfgb = busReq.wr && busReq.addr == `ECP_OFF_CFGB && mode_reg == ECP_M_CFG;
  assign wrEcr  = busReq.wr && busReq.addr == `ECP_OFF_ECR;
  assign rdFifo = busReq.rd && busReq.addr == `ECP_OFF_FIFO;

  assign fifoMode = mode_reg == ECP_M_COMPAT_FIFO_PORT || mode_reg == ECP_M_ECP || mode_reg == ECP_M_TEST;
  // Direction bit is ignored in modes 000 and 010, which only send
  assign dirRev = dcr_reg[`ECP_DCR_DIR] && mode_reg != ECP_M_STD
                  && mode_reg != ECP_M_COMPAT_FIFO_PORT; // see (RULE7) see (RULE8)
  assign fifoFree = `ECP_FIFO_DEPTH - fifoCount;

  // Host side of the shared queue; test mode works in either direction
  assign hostPush = (wrFifo && fifoMode && (!dirRev || mode_reg == ECP_M_TEST))
                  || (wrData && mode_reg == ECP_M_ECP && !dirRev); // see (RULE9) see (RULE19)
  assign hostPop  = rdFifo && (mode_reg == ECP_M_TEST
                  || (mode_reg == ECP_M_ECP && dirRev)); // see (RULE1)
  assign dmaPush  = dmaAck && dma_enable_bit_reg && fifoMode && !dirRev; // see (RULE25)
  assign dmaPop   = dmaAck && dma_enable_bit_reg && dirRev
                  && (mode_reg == ECP_M_ECP || mode_reg == ECP_M_TEST); // see (RULE25)
  assign fifoClear = mode_reg == ECP_M_STD || mode_reg == ECP_M_BIDIR; // see (RULE6) see (RULE24)

  ecp_byte_fifo u_fifo (
    .clk      (clk),
    .rst_b    (rst_b),
    .clear    (fifoClear),
    .push     (hostPush || dmaPush || lnkPush),
    .pushData (lnkPush ? {lineIn.busy, lineIn.pd} : {!wrData, busReq.wdata}),
    .pop      (hostPop || dmaPop || lnkPop),
    .head     (fifoHead),
    .count    (fifoCount),
    .full     (fifoFull),
    .empty    (fifoEmpty)
  );

  // Control registers; reset lands in standard mode with DMA off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg      <= ECP_M_STD; // see (RULE26)
      faultMask_reg <= 1'b0;
      dma_enable_bit_reg     <= 1'b0; // see (RULE26)
      dcr_reg       <= `ECP_DCR_RST;
      dataLatch_reg <= 8'h00;
      cfgbLow_reg   <= `ECP_CFGB_LOW_RST;
    end else begin
      if (wrEcr) begin
        mode_reg      <= ecp_mode_t'(busReq.wdata[7:5]); // see (RULE6)
        faultMask_reg <= busReq.wdata[`ECP_ECR_MASK];
        dma_enable_bit_reg     <= busReq.wdata[`ECP_ECR_DMA_ENABLE_BIT];
      end
      if (wrDcr) dcr_reg <= busReq.wdata[5:0];
      if (wrData && (mode_reg == ECP_M_STD || mode_reg == ECP_M_BIDIR)) begin
        dataLatch_reg <= busReq.wdata;
      end
      if (wrCfgb) cfgbLow_reg <= busReq.wdata[2:0];
    end
  end

  // Service events; a hardware set wins over a same-cycle clear
  always_comb begin
    svcSet = 1'b0;
    if (fifoMode) begin
      if (dma_enable_bit_reg) svcSet = dmaAck && dmaTc; // see (RULE15)
      else if (!dirRev) svcSet = fifoFree >= writeThreshold; // see (RULE16)
      else svcSet = fifoCount >= readThreshold; // see (RULE17)
    end
    svc_next = svc_reg;
    if (wrEcr) svc_next = busReq.wdata[`ECP_ECR_SVC];
    if (svcSet) svc_next = 1'b1; // see (RULE14)
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      svc_reg        <= 1'b0;
      serviceIrq_reg <= 1'b0;
    end else begin
      svc_reg        <= svc_next;
      // Only a hardware set interrupts, so software writing one is silent
      serviceIrq_reg <= svcSet && !svc_reg; // see (RULE14)
    end
  end

  // DMA request; the service bit blocks it as well as the enable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      portDmaReq_reg <= 1'b0;
    end else begin
      portDmaReq_reg <= dma_enable_bit_reg && !svc_next && fifoMode
                        && (dirRev ? (!fifoEmpty && mode_reg != ECP_M_COMPAT_FIFO_PORT)
                                   : !fifoFull); // see (RULE13) see (RULE25)
    end
  end

  // Fault interrupt, meaningful only in ECP mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nFaultPrev_reg <= 1'b1;
      faultIrq_reg   <= 1'b0;
    end else begin
      nFaultPrev_reg <= lineIn.nFault;
      faultIrq_reg   <= mode_reg == ECP_M_ECP && !lineIn.nFault
                        && ((!faultMask_reg && nFaultPrev_reg)
                        || (wrEcr && faultMask_reg
                        && !busReq.wdata[`ECP_ECR_MASK])); // see (RULE12)
    end
  end

  // Read data; capability registers decode only in configuration mode
  always_comb begin
    rdNext = 8'h00;
    case (busReq.addr)
      `ECP_OFF_DATA: rdNext = (mode_reg == ECP_M_BIDIR) ? lineIn.pd
                                                        : dataLatch_reg; // see (RULE7)
      `ECP_OFF_DSR:  rdNext = {!lineIn.busy, lineIn.nAck, lineIn.pError,
                               lineIn.select, lineIn.nFault, 3'h7};
      `ECP_OFF_DCR:  rdNext = {2'h3, dcr_reg};
      `ECP_OFF_FIFO: begin
        if (mode_reg == ECP_M_CFG) rdNext = `ECP_CFGA_VAL; // see (RULE2) see (RULE11)
        else if (hostPop) rdNext = fifoHead[7:0];
      end
      `ECP_OFF_CFGB: begin
        if (mode_reg == ECP_M_CFG) begin
          rdNext = {1'b0, irqLevel, irqSelect, cfgbLow_reg}; // see (RULE3) see (RULE4) see (RULE5)
        end
      end
      `ECP_OFF_ECR:  rdNext = {mode_reg, faultMask_reg, dma_enable_bit_reg, svc_reg,
                               fifoFull, fifoEmpty}; // see (RULE18)
      default:       rdNext = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata_reg <= 8'h00;
    end else if (dmaPop) begin
      regRdata_reg <= fifoHead[7:0];
    end else if (busReq.rd) begin
      regRdata_reg <= rdNext;
    end
  end

  // Cable handshake engine for modes 010 and 011
  assign fwdGo = (mode_reg == ECP_M_COMPAT_FIFO_PORT || mode_reg == ECP_M_ECP)
                 && !dirRev && !fifoEmpty; // see (RULE8) see (RULE9)
  // Reverse waits for the peripheral to acknowledge the request
  assign revGo = mode_reg == ECP_M_ECP && dirRev && !lineIn.pError
                 && !fifoFull; // see (RULE21)

  always_comb begin
    lnk_next = lnk_reg;
    lnkPop   = 1'b0;
    lnkPush  = 1'b0;
    lnkStart = 1'b0;
    case (lnk_reg)
      ECP_LK_IDLE: begin
        if (fwdGo && !dmaPop && !hostPop) begin
          lnkPop   = 1'b1;
          lnkStart = 1'b1;
          lnk_next = ECP_LK_ACT;
        end else if (revGo) begin
          lnkStart = 1'b1;
          lnk_next = ECP_LK_ACT;
        end
      end
      ECP_LK_ACT: begin
        if (!fifoMode || mode_reg == ECP_M_TEST) begin
          lnk_next = ECP_LK_IDLE;
        end else if (!lnkRev_reg && lineIn.busy) begin
          lnk_next = ECP_LK_WAIT;
        end else if (lnkRev_reg && !lineIn.nAck) begin
          lnkPush  = 1'b1; // see (RULE9) see (RULE20)
          lnk_next = ECP_LK_WAIT;
        end
      end
      ECP_LK_WAIT: begin
        if (!fifoMode) lnk_next = ECP_LK_IDLE;
        else if (lnkRev_reg ? lineIn.nAck : !lineIn.busy) lnk_next = ECP_LK_DONE;
      end
      ECP_LK_DONE: lnk_next = ECP_LK_IDLE;
      default:     lnk_next = ECP_LK_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lnk_reg     <= ECP_LK_IDLE;
      lnkRev_reg  <= 1'b0;
      lnkByte_reg <= 9'h100;
    end else begin
      lnk_reg <= lnk_next;
      if (lnkStart) lnkRev_reg <= !fwdGo;
      if (lnkPop) lnkByte_reg <= fifoHead;
    end
  end

  // Cable outputs; test mode never strobes, only shows the FIFO head
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pdOut_reg     <= 8'h00;
      pdOe_reg      <= 1'b1;
      nStrobe_reg   <= 1'b1;
      nAutoFd_reg   <= 1'b1;
      nInit_reg     <= 1'b1;
      nSelectIn_reg <= 1'b1;
      eppActive_reg <= 1'b0;
    end else begin
      case (mode_reg)
        ECP_M_STD, ECP_M_BIDIR: pdOut_reg <= dataLatch_reg;
        ECP_M_TEST:             pdOut_reg <= fifoHead[7:0]; // see (RULE1)
        default:                pdOut_reg <= lnkByte_reg[7:0];
      endcase
      pdOe_reg <= !dirRev && (mode_reg != ECP_M_ECP || lineIn.pError); // see (RULE7) see (RULE21)
      if (mode_reg == ECP_M_STD || mode_reg == ECP_M_BIDIR) begin
        nStrobe_reg <= !dcr_reg[`ECP_DCR_STB];
      end else begin
        nStrobe_reg <= !(lnk_reg == ECP_LK_ACT && !lnkRev_reg); // see (RULE1) see (RULE8)
      end
      if (mode_reg == ECP_M_ECP) begin
        // HostAck high for data, low for a command byte
        nAutoFd_reg <= lnkRev_reg ? (lnk_reg != ECP_LK_ACT)
                                  : (lnk_reg == ECP_LK_IDLE || lnkByte_reg[8]); // see (RULE20)
      end else begin
        nAutoFd_reg <= !dcr_reg[`ECP_DCR_AFD];
      end
      nInit_reg     <= dcr_reg[`ECP_DCR_NINIT]; // see (RULE21)
      nSelectIn_reg <= (mode_reg == ECP_M_ECP) || !dcr_reg[`ECP_DCR_SELIN]; // see (RULE22)
      eppActive_reg <= mode_reg == ECP_M_EPP && eppOption; // see (RULE10)
    end
  end

  a_cfga_value: assert property (@(posedge clk) disable iff (!rst_b)
    rdFifo && mode_reg == ECP_M_CFG |=> regRdata == 8'h10) // see (RULE2)
    else $error("capability A read wrong");
  a_cfgb_top: assert property (@(posedge clk) disable iff (!rst_b)
    busReq.rd && busReq.addr == `ECP_OFF_CFGB && mode_reg == ECP_M_CFG
    |=> !regRdata[7] && regRdata[6] == $past(irqLevel)) // see (RULE3)
    else $error("capability B top bits wrong");
  a_std_clear: assert property (@(posedge clk) disable iff (!rst_b)
    mode_reg == ECP_M_STD |=> fifoEmpty) // see (RULE6)
    else $error("FIFO not empty in standard mode");
  a_dma_off: assert property (@(posedge clk) disable iff (!rst_b)
    !dma_enable_bit_reg ##1 !dma_enable_bit_reg |-> !portDmaReq) // see (RULE13)
    else $error("DMA request while disabled");
  a_svc_block: assert property (@(posedge clk) disable iff (!rst_b)
    svc_reg && !wrEcr |=> !portDmaReq) // see (RULE14)
    else $error("DMA request while service bit set");
  a_tc_sets: assert property (@(posedge clk) disable iff (!rst_b)
    dma_enable_bit_reg && fifoMode && dmaAck && dmaTc |=> svc_reg) // see (RULE15)
    else $error("terminal count missed");
  a_ecp_selin: assert property (@(posedge clk) disable iff (!rst_b)
    mode_reg == ECP_M_ECP |=> nSelectIn) // see (RULE22)
    else $error("select-in asserted in ECP mode");
  a_test_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    mode_reg == ECP_M_TEST [*2] |=> nStrobe) // see (RULE1)
    else $error("strobe in test mode");
  a_full_flag: assert property (@(posedge clk) disable iff (!rst_b)
    busReq.rd && busReq.addr == `ECP_OFF_ECR && !dmaPop
    |=> regRdata[1:0] == {$past(fifoFull), $past(fifoEmpty)}) // see (RULE18)
    else $error("full or empty flag misread");
  a_fault_mask: assert property (@(posedge clk) disable iff (!rst_b)
    faultMask_reg && !wrEcr |=> !faultIrq) // see (RULE12)
    else $error("fault interrupt while masked");
endmodule : ecp_port_extended_control

// ### bench/ecp_periph_model.sv
// Peripheral on the cable: takes forward bytes, sends reverse bytes.
// Assumes the port drives the data lines only while pdOe is high.
`timescale 1ns/1ps
module ecp_periph_model
  import ecp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] pdOut,
  input  wire logic       pdOe,
  input  wire logic       nStrobe,
  input  wire logic       nAutoFd,
  input  wire logic       nInit,
  input  wire logic       nFaultIn,
  input  wire logic [8:0] revByte,
  output ecp_line_t       lineIn,
  output logic            gotByte,
  output logic      [8:0] gotData,
  output logic            revDone
);
  logic [7:0] pdDrv_reg;
  logic       pdOwn_reg;
  logic       busy_reg;
  logic       nAck_reg;
  logic [1:0] lag_reg;
  // Released lines show the inverse, so a stale byte never reads as fresh
  assign lineIn = {pdOe ? pdOut : (pdOwn_reg ? pdDrv_reg : ~pdDrv_reg), nAck_reg,
                   busy_reg, nInit, 1'b1, nFaultIn};
  // Event outputs toggle, so back-to-back bytes never merge into one pulse
  initial begin
    busy_reg = 1'b0;
    nAck_reg = 1'b1;
    pdOwn_reg = 1'b0;
    pdDrv_reg = 8'hA5;
    gotByte = 1'b0;
    gotData = 9'h000;
    revDone = 1'b0;
    lag_reg = 2'h0;
    forever begin
      @(posedge clk);
      if (!nStrobe && !busy_reg) begin
        repeat (lag_reg) @(posedge clk);
        lag_reg <= lag_reg + 2'h3;
        gotData <= {nAutoFd, lineIn.pd};
        gotByte <= ~gotByte;
        busy_reg <= 1'b1;
      end else if (nStrobe && busy_reg && nInit) begin
        busy_reg <= 1'b0;
      end else if (!nInit && !nAutoFd && nAck_reg) begin
        pdOwn_reg <= 1'b1;
        pdDrv_reg <= revByte[7:0];
        busy_reg <= revByte[8];
        @(posedge clk);
        nAck_reg <= 1'b0;
      end else if (nAutoFd && !nAck_reg) begin
        nAck_reg <= 1'b1;
        pdOwn_reg <= 1'b0;
        revDone <= ~revDone;
      end
    end
  end
endmodule : ecp_periph_model

// ### bench/tb.sv
// Self-checking bench: registers, FIFO modes, DMA, service and fault events.
// Assumes ecp_pkg, the port map header and the peripheral model compile first.
`timescale 1ns/1ps
`include "ecp_port_map.svh"
module tb
  import ecp_pkg::*;
;
  logic        clk, rst_b, dmaAck, dmaTc, irqLevel, eppOption, nFaultIn, lvl;
  ecp_req_t    busReq;
  ecp_line_t   lineIn;
  logic [2:0]  irqSelect;
  logic [4:0]  writeThreshold, readThreshold;
  logic [7:0]  regRdata, pdOut, v;
  logic        pdOe, nStrobe, nAutoFd, nInit, nSelectIn;
  logic        portDmaReq, faultIrq, serviceIrq, eppActive, gotByte, revDone;
  logic [8:0]  gotData, revByte;
  logic [31:0] seed;
  logic [8:0]  cabQ[$];
  logic [7:0]  fifoQ[$];
  int          err_count, compares, cyc, nSvc, nFlt, n, t;
  ecp_port_extended_control dut_u (.clk, .rst_b, .busReq, .dmaAck, .dmaTc, .lineIn,
    .irqLevel, .irqSelect, .eppOption, .writeThreshold, .readThreshold, .regRdata,
    .pdOut, .pdOe, .nStrobe, .nAutoFd, .nInit, .nSelectIn, .portDmaReq, .faultIrq,
    .serviceIrq, .eppActive);
  ecp_periph_model periph_u (.clk, .pdOut, .pdOe, .nStrobe, .nAutoFd, .nInit,
    .nFaultIn, .revByte, .lineIn, .gotByte, .gotData, .revDone);
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string s, input logic [8:0] e, input logic [8:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic cnt(input string s, input int e, input int g);
    compares++;
    if (g != e) begin
      err_count++;
      $display("mismatch %s expected %0d seen %0d", s, e, g);
    end
  endtask : cnt
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk);
    busReq <= '{a, 1'b1, 1'b0, d};
    @(posedge clk);
    busReq <= '0;
  endtask : wr
  // Read data stands until the next read or DMA pop, so it is taken one edge late
  task automatic rd(input logic [10:0] a);
    @(posedge clk);
    busReq <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge clk);
    busReq <= '0;
    @(posedge clk);
    #1 v = regRdata;
  endtask : rd
  task automatic rchk(input string s, input logic [10:0] a, input logic [7:0] e,
                      input logic [7:0] m);
    rd(a);
    chk(s, {1'b0, e & m}, {1'b0, v & m});
  endtask : rchk
  task automatic fill(input int k);
    repeat (k) begin
      v = rnd();
      fifoQ.push_back(v);
      wr(`ECP_OFF_FIFO, v);
    end
  endtask : fill
  task automatic drain(input int k);
    repeat (k) begin
      rd(`ECP_OFF_FIFO);
      chk("fifo byte", {1'b0, fifoQ.pop_front()}, {1'b0, v});
    end
  endtask : drain
  task automatic settle();
    for (int k = 0; k < 3000 && cabQ.size() > 0; k++) @(posedge clk);
    chk("cable drained", 9'h001, {8'h00, cabQ.size() == 0});
    repeat (8) @(posedge clk);
  endtask : settle
  task automatic dma(input logic [7:0] d, input logic tc);
    @(negedge clk);
    for (int k = 0; k < 200 && portDmaReq !== 1'b1; k++) @(negedge clk);
    chk("dma request", 9'h001, {8'h00, portDmaReq});
    cabQ.push_back({1'b1, d});
    @(posedge clk);
    dmaAck <= 1'b1;
    dmaTc <= tc;
    busReq.wdata <= d;
    @(posedge clk);
    dmaAck <= 1'b0;
    dmaTc <= 1'b0;
  endtask : dma
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (serviceIrq === 1'b1) nSvc <= nSvc + 1;
    if (faultIrq === 1'b1) nFlt <= nFlt + 1;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  always @(gotByte) if (rst_b === 1'b1) begin
    chk("select in", 9'h001, {8'h00, nSelectIn});
    chk("cable byte", cabQ.size() == 0 ? 9'h1FF : cabQ.pop_front(), gotData);
  end
  always @(revDone) if (rst_b === 1'b1) begin
    fifoQ.push_back(revByte[7:0]);
    revByte <= {1'b1, rnd()};
  end
  initial begin
    seed = 32'h9217;
    busReq = '0;
    {dmaAck, dmaTc, irqLevel, eppOption, irqSelect} = '0;
    nFaultIn = 1'b1;
    writeThreshold = 5'h08;
    readThreshold = 5'h02;
    revByte = 9'h1C3;
    {err_count, compares, cyc, nSvc, nFlt} = '0;
    rst_b = 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rchk("mode after reset", `ECP_OFF_ECR, 8'h01, 8'hFB);
    wr(`ECP_OFF_FIFO, 8'h55);
    rchk("fifo disabled", `ECP_OFF_ECR, 8'h01, 8'h03);
    rchk("capability hidden", `ECP_OFF_FIFO, 8'h00, 8'hFF);
    done("reset");
    wr(`ECP_OFF_ECR, 8'hE4);
    rchk("capability a", `ECP_OFF_FIFO, 8'h10, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      lvl = ^rnd();
      irqLevel <= lvl;
      irqSelect <= i[2:0];
      rchk("cap b", `ECP_OFF_CFGB, {1'b0, lvl, i[2:0], 3'h7}, 8'hFF);
    end
    wr(`ECP_OFF_CFGB, 8'hF8);
    rchk("capability b write", `ECP_OFF_CFGB, {1'b0, lvl, 6'h38}, 8'hFF);
    done("capability");
    wr(`ECP_OFF_ECR, 8'h04);
    wr(`ECP_OFF_ECR, 8'hC4);
    fill(16);
    wr(`ECP_OFF_FIFO, 8'hE7);
    rchk("full flag", `ECP_OFF_ECR, 8'h02, 8'h03);
    chk("no dma request", 9'h000, {8'h00, portDmaReq});
    drain(16);
    rchk("empty flag", `ECP_OFF_ECR, 8'h01, 8'h03);
    wr(`ECP_OFF_FIFO, 8'h3C);
    wr(`ECP_OFF_ECR, 8'h04);
    wr(`ECP_OFF_ECR, 8'hC4);
    rchk("fifo cleared", `ECP_OFF_ECR, 8'hC5, 8'hFF);
    done("test fifo");
    wr(`ECP_OFF_ECR, 8'h04);
    wr(`ECP_OFF_ECR, 8'h64);
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      cabQ.push_back({i[0], v});
      wr(i[0] ? `ECP_OFF_FIFO : `ECP_OFF_DATA, v);
    end
    settle();
    n = nFlt;
    nFaultIn <= 1'b0;
    repeat (8) @(posedge clk);
    cnt("fault edge", n + 1, nFlt);
    wr(`ECP_OFF_ECR, 8'h74);
    nFaultIn <= 1'b1;
    repeat (4) @(posedge clk);
    nFaultIn <= 1'b0;
    repeat (8) @(posedge clk);
    cnt("masked fault", n + 1, nFlt);
    wr(`ECP_OFF_ECR, 8'h64);
    repeat (8) @(posedge clk);
    cnt("unmasked fault", n + 2, nFlt);
    nFaultIn <= 1'b1;
    done("ecp forward");
    wr(`ECP_OFF_ECR, 8'h04);
    n = nSvc;
    wr(`ECP_OFF_ECR, 8'h48);
    for (int i = 0; i < 4; i++) dma(rnd(), i == 3);
    repeat (4) @(posedge clk);
    cnt("terminal count", n + 1, nSvc);
    chk("dma stopped", 9'h000, {8'h00, portDmaReq});
    rchk("service bit", `ECP_OFF_ECR, 8'h4C, 8'hEC);
    settle();
    done("dma");
    wr(`ECP_OFF_ECR, 8'h04);
    n = nSvc;
    wr(`ECP_OFF_ECR, 8'hC4);
    t = rnd() % 16 + 1;
    writeThreshold <= t[4:0];
    fill(17 - t);
    wr(`ECP_OFF_ECR, 8'hC0);
    repeat (8) @(posedge clk);
    cnt("below threshold", n, nSvc);
    drain(1);
    repeat (8) @(posedge clk);
    cnt("at threshold", n + 1, nSvc);
    rchk("service set", `ECP_OFF_ECR, 8'hC4, 8'hE4);
    drain(16 - t);
    done("threshold");
    wr(`ECP_OFF_ECR, 8'h04);
    wr(`ECP_OFF_ECR, 8'h24);
    wr(`ECP_OFF_DCR, 8'h20);
    repeat (2) @(posedge clk);
    chk("bidir released", 9'h000, {8'h00, pdOe});
    // Released lines read as the inverse of the model's idle byte A5
    rchk("bidir data", `ECP_OFF_DATA, 8'h5A, 8'hFF);
    n = nSvc;
    wr(`ECP_OFF_ECR, 8'h60);
    for (int k = 0; k < 2000 && fifoQ.size() < 16; k++) @(posedge clk);
    chk("reverse released", 9'h000, {8'h00, pdOe});
    cnt("read threshold", n + 1, nSvc);
    drain(16);
    done("reverse");
    for (int i = 0; i < 2; i++) begin
      wr(`ECP_OFF_ECR, 8'h04);
      eppOption <= i[0];
      wr(`ECP_OFF_ECR, 8'h84);
      repeat (2) @(posedge clk);
      chk("epp active", {8'h00, i[0]}, {8'h00, eppActive});
    end
    done("epp");
    end_of_test();
  end
endmodule : tb
